// ===== bench/lhd_host_model.sv
// host microprocessor model on the parallel command port
`timescale 1ns/10ps

module lhd_host_model (
    input  wire logic       sys_clk,
    input  wire logic       mode_6800,
    input  wire logic [7:0] dout,
    input  wire logic       oe,
    output logic            cs_n,
    output logic            rd,
    output logic            wr,
    output logic            a0,
    output logic [7:0]      bus
);
    logic       drv;
    logic [7:0] wdata;
    logic [7:0] junk_q;

    // released bus wanders, device drive wins while enabled
    always @(posedge sys_clk) junk_q <= ~junk_q;
    assign bus = oe ? dout : (drv ? wdata : junk_q);

    initial begin
        drv = 1'b0;
        wdata = 8'h00;
        junk_q = 8'h5a;
        cs_n = 1'b1;
        rd = 1'b1;
        wr = 1'b1;
        a0 = 1'b0;
    end

    task automatic set_idle();
        @(negedge sys_clk);
        rd = !mode_6800;
        wr = 1'b1;
    endtask

    task automatic wr_byte(input logic is_op, input logic [7:0] val);
        @(negedge sys_clk);
        wdata = val;
        a0 = is_op;
        drv = 1'b1;
        cs_n = 1'b0;
        wr = 1'b0;
        if (mode_6800) rd = 1'b1;
        @(negedge sys_clk);
        if (mode_6800) rd = 1'b0;
        else wr = 1'b1;
        @(negedge sys_clk);
        drv = 1'b0;
        cs_n = 1'b1;
        wr = 1'b1;
    endtask

    // a new opcode may cut a parameter list short
    task automatic cmd(input logic [7:0] op);
        wr_byte(1'b1, op);
    endtask

    task automatic rd_byte(output logic [7:0] val, output logic seen_oe);
        @(negedge sys_clk);
        cs_n = 1'b0;
        a0 = 1'b1;
        if (mode_6800) rd = 1'b1;
        else rd = 1'b0;
        repeat (2) @(negedge sys_clk);
        val = bus;
        seen_oe = oe;
        rd = !mode_6800;
        @(negedge sys_clk);
        cs_n = 1'b1;
    endtask
endmodule

// ===== bench/tb_lcd_host_command_decoder.sv
// self-checking bench for the lcd host command decoder
`timescale 1ns/10ps

module tb_lcd_host_command_decoder
    import lhd_pkg::*;
;
    logic                  sys_clk;
    logic                  rstn;
    logic                  cs_n;
    logic                  rd;
    logic                  wr;
    logic                  a0;
    logic [7:0]            bus;
    logic [7:0]            dout;
    logic                  oe;
    logic                  sel_a;
    logic                  sel_b;
    logic                  ready;
    logic [NPARAM-1:0][7:0] prm;
    logic                  dir0;
    logic                  dir1;
    logic                  mem_wvalid;
    logic [7:0]            mem_wdata;
    logic                  mem_wready;
    logic                  restart;
    logic                  pwr_n;
    logic [7:0]            memq[$];
    int                    restarts;
    int                    err_count;
    int                    checked;

    lhd_decoder dut (
        .sys_clk(sys_clk), .rstn(rstn), .host_cs_n(cs_n), .host_rd_pin(rd),
        .host_wr_pin(wr), .data_type_select(a0), .bus_type_sel_a(sel_a),
        .bus_type_sel_b(sel_b), .host_data_in(bus), .host_data_out(dout),
        .host_data_oe(oe), .host_ready(ready), .param_bytes(prm),
        .cursor_dir_bit0(dir0), .cursor_dir_bit1(dir1), .mem_wvalid(mem_wvalid),
        .mem_wdata(mem_wdata), .mem_wready(mem_wready), .timing_restart(restart),
        .panel_powerdown_out_n(pwr_n)
    );

    lhd_host_model host (
        .sys_clk(sys_clk), .mode_6800(sel_a & !sel_b), .dout(dout), .oe(oe),
        .cs_n(cs_n), .rd(rd), .wr(wr), .a0(a0), .bus(bus)
    );

    always #25 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (restart === 1'b1) restarts++;
        if (mem_wvalid === 1'b1 && mem_wready === 1'b1) memq.push_back(mem_wdata);
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic settle();
        repeat (5) @(negedge sys_clk);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic t_dir();
        for (int i = 0; i < 4; i++) begin
            host.cmd(OP_DIR_BASE + 8'(i));
            settle();
            check({6'h00, dir1, dir0}, 8'(i));
        end
    endtask

    task automatic t_hscroll(input logic [7:0] v);
        host.cmd(OP_HSCROLL);
        host.wr_byte(1'b0, v);
        settle();
        check(prm[22], v);
        host.wr_byte(1'b0, ~v);
        settle();
        check(prm[22], v);
    endtask

    task automatic t_pair(input logic [7:0] op, input logic [4:0] b, input logic [7:0] v);
        host.cmd(op);
        host.wr_byte(1'b0, v);
        host.cmd(OP_LAYER);
        settle();
        check(prm[b], 8'h00);
        host.cmd(op);
        host.wr_byte(1'b0, v);
        host.wr_byte(1'b0, v + 8'h01);
        settle();
        check(prm[b], v);
        check(prm[b + 5'h01], v + 8'h01);
    endtask

    task automatic t_csr(input logic [7:0] lo);
        logic [7:0] v;
        logic       e;
        host.cmd(OP_CSR_READ);
        host.rd_byte(v, e);
        check(v, lo);
        check({7'h00, e}, 8'h01);
        host.rd_byte(v, e);
        check(v, 8'h00);
    endtask

    task automatic t_init();
        int n;
        n = restarts;
        host.cmd(OP_SYS_INIT);
        host.wr_byte(1'b0, 8'h30);
        host.cmd(OP_DISP_OFF);
        settle();
        check(8'(restarts - n), 8'h01);
        check(prm[0], 8'h30);
        check({7'h00, pwr_n}, 8'h00);
        host.cmd(OP_DISP_ON);
        settle();
        check({7'h00, pwr_n}, 8'h01);
        host.cmd(OP_SLEEP);
        settle();
        check({7'h00, pwr_n}, 8'h00);
        host.cmd(OP_SYS_INIT);
        for (int i = 0; i < 7; i++) host.wr_byte(1'b0, 8'h30 + 8'(i));
        host.cmd(OP_LAYER);
        settle();
        check(prm[6], 8'h36);
        check(prm[7], 8'h00);
    endtask

    task automatic t_stream();
        int n;
        n = 0;
        mem_wready = 1'b0;
        host.cmd(OP_MEM_WRITE);
        while (ready === 1'b1 && n < 20) begin
            host.wr_byte(1'b0, 8'ha0 + 8'(n));
            n++;
            @(negedge sys_clk);
        end
        check({7'h00, ready}, 8'h00);
        check(8'(n >= FIFO_DEPTH), 8'h01);
        host.wr_byte(1'b0, 8'hee);
        @(negedge sys_clk);
        mem_wready = 1'b1;
        repeat (40) @(negedge sys_clk);
        check(8'(memq.size()), 8'(n));
        for (int i = 0; i < memq.size(); i++) check(memq[i], 8'ha0 + 8'(i));
        host.cmd(OP_LAYER);
        host.wr_byte(1'b0, 8'h11);
        settle();
        check(8'(memq.size()), 8'(n));
        check(prm[23], 8'h11);
    endtask

    initial begin
        sys_clk = 1'b0;
        rstn = 1'b0;
        sel_a = 1'b0;
        sel_b = 1'b0;
        mem_wready = 1'b1;
        restarts = 0;
        err_count = 0;
        checked = 0;
        repeat (4) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (2) @(negedge sys_clk);
        t_dir();
        t_hscroll(8'h03);
        t_pair(OP_REGION, BASE_REGION, 8'h21);
        t_pair(OP_CHAR_RAM, BASE_CHAR, 8'h44);
        host.cmd(OP_CSR_WRITE);
        host.wr_byte(1'b0, 8'h3c);
        host.cmd(OP_LAYER);
        settle();
        check(prm[25], 8'h3c);
        check(prm[26], 8'h00);
        t_csr(8'h3c);
        t_init();
        t_stream();
        @(negedge sys_clk);
        sel_a = 1'b1;
        host.set_idle();
        t_hscroll(8'h5e);
        t_csr(8'h3c);
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        finish_test();
    end
endmodule

// ===== src/lhd_decoder.sv
// host port, input fifo and command decoder of the lcd controller
`timescale 1ns/10ps

module lhd_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = DEPTH[AW:0];

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wptr_q;
    logic [AW-1:0]    rptr_q;
    logic [AW:0]      count_q;
    logic [AW:0]      count_d;
    logic             push;
    logic             pop;

    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign out_data = mem_q[rptr_q];

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wptr_q] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wptr_q    <= '0;
            rptr_q    <= '0;
            count_q   <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            wptr_q    <= push ? wptr_q + 1'b1 : wptr_q;
            rptr_q    <= pop ? rptr_q + 1'b1 : rptr_q;
            count_q   <= count_d;
            in_ready  <= count_d != FULL;
            out_valid <= count_d != '0;
        end
    end
endmodule

module lhd_decoder
    import lhd_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    input  wire logic                  host_cs_n,
    input  wire logic                  host_rd_pin,
    input  wire logic                  host_wr_pin,
    input  wire logic                  data_type_select,
    input  wire logic                  bus_type_sel_a,
    input  wire logic                  bus_type_sel_b,
    input  wire logic [7:0]            host_data_in,
    output logic [7:0]                 host_data_out,
    output logic                       host_data_oe,
    output logic                       host_ready,
    output logic [NPARAM-1:0][7:0]     param_bytes,
    output logic                       cursor_dir_bit0,
    output logic                       cursor_dir_bit1,
    output logic                       mem_wvalid,
    output logic [7:0]                 mem_wdata,
    input  wire logic                  mem_wready,
    output logic                       timing_restart,
    output logic                       panel_powerdown_out_n
);
    lhd_bus_t  bus_cur;
    lhd_bus_t  bus_prev_q;
    lhd_word_t in_word;
    lhd_word_t word;
    lhd_cmd_t  cmd_q;
    logic [3:0] pidx_q;
    logic [7:0] hold_q;
    logic       rd_sel_q;
    logic       mode_6800;
    logic       wr_ev;
    logic       rd_end;
    logic       rd_act;
    logic       word_valid;
    logic       dec_ready;
    logic       take;
    logic       take_cmd;
    logic       take_par;
    logic       has_slot;
    logic [4:0] slot;
    logic       standby_q;
    logic       display_on_q;
    logic       standby_d;
    logic       display_on_d;

    function automatic lhd_cmd_t decode_cmd(input logic [7:0] op);
        if ((op & OP_DIR_MASK) == OP_DIR_BASE) return LHD_DIR;
        unique case (op)
            OP_SYS_INIT:              return LHD_SYS;
            OP_SLEEP:                 return LHD_SLEEP;
            OP_DISP_OFF, OP_DISP_ON:  return LHD_DISP;
            OP_REGION:                return LHD_REGION;
            OP_CSR_SHAPE:             return LHD_SHAPE;
            OP_CHAR_RAM:              return LHD_CHAR;
            OP_HSCROLL:               return LHD_HSCR;
            OP_LAYER:                 return LHD_LAYER;
            OP_CSR_WRITE:             return LHD_CURSOR_ADDR_WRITE_COMMAND;
            OP_CSR_READ:              return LHD_CURSOR_ADDR_READ_COMMAND;
            OP_MEM_WRITE:             return LHD_MEM_WRITE_COMMAND;
            OP_MEM_READ:              return LHD_MEM_READ_COMMAND;
            default:                  return LHD_NONE;
        endcase
    endfunction

    function automatic logic [4:0] cmd_base(input lhd_cmd_t c);
        unique case (c)
            LHD_REGION:        return BASE_REGION;
            LHD_SHAPE:         return BASE_SHAPE;
            LHD_CHAR:          return BASE_CHAR;
            LHD_HSCR:          return BASE_HSCR;
            LHD_LAYER:         return BASE_LAYER;
            LHD_DISP:          return BASE_DISP;
            LHD_CURSOR_ADDR_WRITE_COMMAND, LHD_CURSOR_ADDR_READ_COMMAND: return BASE_CSR;
            default:           return BASE_SYS;
        endcase
    endfunction

    function automatic logic [3:0] cmd_len(input lhd_cmd_t c);
        unique case (c)
            LHD_SYS:                       return LEN_SYS;
            LHD_REGION:                    return LEN_REGION;
            LHD_SHAPE, LHD_CHAR:           return LEN_PAIR;
            LHD_CURSOR_ADDR_WRITE_COMMAND, LHD_CURSOR_ADDR_READ_COMMAND:            return LEN_PAIR;
            LHD_HSCR, LHD_LAYER, LHD_DISP: return LEN_ONE;
            default:                       return LEN_NONE;
        endcase
    endfunction

    // true when the byte at idx opens a two-byte item
    function automatic logic pair_first(input lhd_cmd_t c, input logic [3:0] idx);
        unique case (c)
            LHD_SYS:    return SYS_PAIRS[idx[2:0]];
            LHD_REGION: return REGION_PAIRS[idx];
            LHD_CHAR:   return CHAR_PAIRS[idx[0]];
            default:    return 1'b0;
        endcase
    endfunction

    // host port sampling and strobe roles
    assign bus_cur   = '{cs_n: host_cs_n, rd: host_rd_pin, wr: host_wr_pin,
                         a0: data_type_select, data: host_data_in};
    assign mode_6800 = bus_type_sel_a && !bus_type_sel_b;
    assign wr_ev = mode_6800
        ? (!bus_prev_q.cs_n && bus_prev_q.rd && !bus_cur.rd && !bus_prev_q.wr)
        : (!bus_prev_q.cs_n && !bus_prev_q.wr && bus_cur.wr);
    assign rd_end = mode_6800
        ? (!bus_prev_q.cs_n && bus_prev_q.rd && !bus_cur.rd && bus_prev_q.wr)
        : (!bus_prev_q.cs_n && !bus_prev_q.rd && bus_cur.rd);
    assign rd_act = mode_6800
        ? (!host_cs_n && host_rd_pin && host_wr_pin)
        : (!host_cs_n && !host_rd_pin);
    assign in_word = '{is_cmd: bus_prev_q.a0, data: bus_prev_q.data};

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bus_prev_q <= '{cs_n: 1'b1, rd: 1'b1, wr: 1'b1, a0: 1'b0, data: 8'h00};
        end else begin
            bus_prev_q <= bus_cur;
        end
    end

    lhd_fifo #(
        .WIDTH ($bits(lhd_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .in_valid  (wr_ev),
        .in_ready  (host_ready),
        .in_data   (in_word),
        .out_valid (word_valid),
        .out_ready (dec_ready),
        .out_data  (word)
    );

    assign dec_ready = !mem_wvalid || mem_wready;
    assign take      = word_valid && dec_ready;
    assign take_cmd  = take && word.is_cmd;
    assign take_par  = take && !word.is_cmd;
    assign has_slot  = pidx_q < cmd_len(cmd_q);
    assign slot      = 5'(cmd_base(cmd_q) + 5'(pidx_q));

    // command and parameter position
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_q  <= LHD_NONE;
            pidx_q <= '0;
        end else if (take_cmd) begin
            cmd_q  <= decode_cmd(word.data);
            pidx_q <= '0;
        end else if (take_par && pidx_q != IDX_MAX) begin
            pidx_q <= pidx_q + 1'b1;
        end
    end

    // parameter registers, written byte by byte or pairwise
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            param_bytes <= '0;
            hold_q      <= '0;
        end else if (take_par && has_slot) begin
            if (pair_first(cmd_q, pidx_q)) begin
                hold_q <= word.data;
            end else if (pidx_q != '0 && pair_first(cmd_q, pidx_q - 1'b1)) begin
                param_bytes[slot - 1'b1] <= hold_q;
                param_bytes[slot]        <= word.data;
            end else begin
                param_bytes[slot] <= word.data;
            end
        end
    end

    // cursor direction from opcode low bits
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cursor_dir_bit0 <= 1'b0;
            cursor_dir_bit1 <= 1'b0;
        end else if (take_cmd && decode_cmd(word.data) == LHD_DIR) begin
            cursor_dir_bit0 <= word.data[0];
            cursor_dir_bit1 <= word.data[1];
        end
    end

    // display memory write stream
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mem_wvalid <= 1'b0;
            mem_wdata  <= 8'h00;
        end else if (take_par && cmd_q == LHD_MEM_WRITE_COMMAND) begin
            mem_wvalid <= 1'b1;
            mem_wdata  <= word.data;
        end else if (mem_wready) begin
            mem_wvalid <= 1'b0;
        end
    end

    // standby, display enable and panel power-down
    always_comb begin
        standby_d    = standby_q;
        display_on_d = display_on_q;
        if (take_cmd && word.data == OP_SLEEP) begin
            standby_d = 1'b1;
        end else if (take_cmd && word.data == OP_DISP_ON) begin
            display_on_d = 1'b1;
        end else if (take_cmd && word.data == OP_DISP_OFF) begin
            display_on_d = 1'b0;
        end else if (take_par && cmd_q == LHD_SYS && pidx_q == '0) begin
            standby_d    = 1'b0;
            display_on_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            standby_q             <= 1'b0;
            display_on_q          <= 1'b0;
            panel_powerdown_out_n <= 1'b0;
            timing_restart        <= 1'b0;
        end else begin
            standby_q             <= standby_d;
            display_on_q          <= display_on_d;
            panel_powerdown_out_n <= display_on_d && !standby_d;
            timing_restart        <= take_par && cmd_q == LHD_SYS && pidx_q == '0;
        end
    end

    // host read path: cursor bytes after 47, else status
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_sel_q      <= 1'b0;
            host_data_out <= 8'h00;
            host_data_oe  <= 1'b0;
        end else begin
            if (take_cmd) begin
                rd_sel_q <= 1'b0;
            end else if (rd_end && cmd_q == LHD_CURSOR_ADDR_READ_COMMAND) begin
                rd_sel_q <= !rd_sel_q;
            end
            host_data_oe <= rd_act;
            if (cmd_q == LHD_CURSOR_ADDR_READ_COMMAND) begin
                host_data_out <= param_bytes[BASE_CSR + 5'(rd_sel_q)];
            end else begin
                host_data_out <= 8'h00;
                host_data_out[STATUS_FULL_BIT] <= !host_ready;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    property p_dir;
        take_cmd && ((word.data & OP_DIR_MASK) == OP_DIR_BASE)
            |=> {cursor_dir_bit1, cursor_dir_bit0} == $past(word.data[1:0]);
    endproperty
    a_dir: assert property (p_dir) else $error("cursor direction not taken");

    property p_hscr;
        take_par && cmd_q == LHD_HSCR && pidx_q == '0
            |=> param_bytes[BASE_HSCR] == $past(word.data);
    endproperty
    a_hscr: assert property (p_hscr) else $error("scroll byte not stored");

    property p_mem_write_command;
        take_par && cmd_q == LHD_MEM_WRITE_COMMAND |=> mem_wvalid && mem_wdata == $past(word.data);
    endproperty
    a_mem_write_command: assert property (p_mem_write_command) else $error("memory write byte lost");

    property p_char_pair;
        take_par && cmd_q == LHD_CHAR && pidx_q == '0
            |=> $stable(param_bytes[BASE_CHAR]) && $stable(param_bytes[BASE_CHAR + 5'h1]);
    endproperty
    a_char_pair: assert property (p_char_pair) else $error("half pair committed");

    property p_pitch;
        take_par && cmd_q == LHD_SYS && pidx_q == SYS_PITCH_LO
            |=> param_bytes[BASE_SYS + 5'(SYS_PITCH_LO)] == $past(word.data);
    endproperty
    a_pitch: assert property (p_pitch) else $error("pitch low not immediate");

    property p_keep;
        take_cmd |=> $stable(param_bytes);
    endproperty
    a_keep: assert property (p_keep) else $error("opcode altered parameters");

    property p_csr_low;
        take_par && cmd_q == LHD_CURSOR_ADDR_WRITE_COMMAND && pidx_q == '0 |=> param_bytes[BASE_CSR] == $past(word.data);
    endproperty
    a_csr_low: assert property (p_csr_low) else $error("cursor low byte not stored");

    property p_push;
        wr_ev && host_ready |=> word_valid;
    endproperty
    a_push: assert property (p_push) else $error("host write not queued");

    property p_sleep;
        take_cmd && word.data == OP_SLEEP |=> !panel_powerdown_out_n ##1 standby_q;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep did not blank panel");

    property p_init;
        take_par && cmd_q == LHD_SYS && pidx_q == '0 |=> timing_restart && !standby_q
            && !display_on_q ##1 !timing_restart;
    endproperty
    a_init: assert property (p_init) else $error("init byte did not restart");
endmodule

// ===== src/lhd_pkg.sv
// constants, commands and carriers for the lcd host command decoder
package lhd_pkg;
    localparam logic [7:0] OP_SYS_INIT   = 8'h40;
    localparam logic [7:0] OP_MEM_WRITE  = 8'h42;
    localparam logic [7:0] OP_MEM_READ   = 8'h43;
    localparam logic [7:0] OP_REGION     = 8'h44;
    localparam logic [7:0] OP_CSR_WRITE  = 8'h46;
    localparam logic [7:0] OP_CSR_READ   = 8'h47;
    localparam logic [7:0] OP_SLEEP      = 8'h53;
    localparam logic [7:0] OP_DISP_OFF   = 8'h58;
    localparam logic [7:0] OP_DISP_ON    = 8'h59;
    localparam logic [7:0] OP_HSCROLL    = 8'h5a;
    localparam logic [7:0] OP_LAYER      = 8'h5b;
    localparam logic [7:0] OP_CHAR_RAM   = 8'h5c;
    localparam logic [7:0] OP_CSR_SHAPE  = 8'h5d;
    localparam logic [7:0] OP_DIR_MASK   = 8'hfc;
    localparam logic [7:0] OP_DIR_BASE   = 8'h4c;

    typedef enum logic [3:0] {
        LHD_NONE, LHD_SYS, LHD_SLEEP, LHD_DISP, LHD_REGION, LHD_SHAPE, LHD_CHAR,
        LHD_DIR, LHD_HSCR, LHD_LAYER, LHD_CURSOR_ADDR_WRITE_COMMAND, LHD_CURSOR_ADDR_READ_COMMAND, LHD_MEM_WRITE_COMMAND, LHD_MEM_READ_COMMAND
    } lhd_cmd_t;

    localparam int         NPARAM      = 27;
    localparam logic [4:0] BASE_SYS    = 5'h00;
    localparam logic [4:0] BASE_REGION = 5'h08;
    localparam logic [4:0] BASE_SHAPE  = 5'h12;
    localparam logic [4:0] BASE_CHAR   = 5'h14;
    localparam logic [4:0] BASE_HSCR   = 5'h16;
    localparam logic [4:0] BASE_LAYER  = 5'h17;
    localparam logic [4:0] BASE_DISP   = 5'h18;
    localparam logic [4:0] BASE_CSR    = 5'h19;
    localparam logic [3:0] LEN_SYS     = 4'h8;
    localparam logic [3:0] LEN_REGION  = 4'ha;
    localparam logic [3:0] LEN_PAIR    = 4'h2;
    localparam logic [3:0] LEN_ONE     = 4'h1;
    localparam logic [3:0] LEN_NONE    = 4'h0;
    localparam logic [3:0] IDX_MAX     = 4'hf;
    localparam logic [3:0] SYS_PITCH_LO = 4'h6;
    localparam logic [9:0] REGION_PAIRS = 10'h149;
    localparam logic [1:0] CHAR_PAIRS   = 2'h1;
    localparam logic [7:0] SYS_PAIRS    = 8'h00;
    localparam int         STATUS_FULL_BIT = 6;
    localparam int         FIFO_DEPTH  = 8;

    typedef struct packed {
        logic       is_cmd;
        logic [7:0] data;
    } lhd_word_t;

    typedef struct packed {
        logic       cs_n;
        logic       rd;
        logic       wr;
        logic       a0;
        logic [7:0] data;
    } lhd_bus_t;
endpackage
